// File: src/dslp_ctrl.v
/*
 Deep-sleep clock and power control slice: AHB-Lite register slave, the
 sleep/run clock selection, oscillator power-down decisions, memory and
 analog low-power options, and per-port bus attachment.
 Assumes one 100 MHz clock, the core flags deep sleep as a level, and
 hibernation presence/enable arrive as asynchronous levels.
*/
`timescale 1ns/1ps
`include "dslp_defines.vh"

module dslp_ctrl (
	input wire clk,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire core_deep_sleep,
	input wire hib_present,
	input wire hib_enabled,
	input wire [31:0] periph_run_en,
	output reg [1:0] clk_src_sel,
	output reg [9:0] clk_div_m1,
	output reg precision_osc_on,
	output reg main_osc_on,
	output reg flash_reduced_power,
	output reg [1:0] sram_power,
	output reg regulator_sleep_mode,
	output reg temp_sensor_reduced_power,
	output reg [31:0] periph_clk_en,
	output reg [8:0] port_on_ahb,
	output reg [8:0] port_on_apb
);

	// Registers. Sleep and run settings are held apart so that waking
	// needs no software restore of the run clock.
	reg [9:0] sleep_div;
	reg [1:0] sleep_src;
	reg sleep_precision_osc_powerdown;
	reg sleep_main_osc_powerdown;
	reg use_legacy;
	reg [5:0] legacy_div;
	reg flash_low;
	reg [1:0] sram_cfg;
	reg ldo_sleep;
	reg temp_low;
	reg clock_gating;
	reg [8:0] port_ahb_sel;
	reg [1:0] run_src;
	reg [9:0] run_div;
	reg [31:0] periph_sleep_en;
	reg [8:0] ahb_only;

	// AHB data-phase capture
	reg wr_pend;
	reg [11:0] wr_addr;

	// Synchronisers for hibernation levels, three stages each
	reg [2:0] hib_p_sync;
	reg [2:0] hib_e_sync;
	reg hib_ok;

	// Core sleep flag comes from same-clock logic
	wire in_sleep = core_deep_sleep;
	wire [1:0] eff_src;
	wire [9:0] eff_div;
	wire addr_ok = hsel && htrans[1] && hready;
	wire [11:0] a = haddr[11:0];
	// Per-port attachment computed ahead of the output flops
	wire [8:0] next_port_ahb;
	wire [8:0] next_port_apb;

	// Hibernation as sleep source only legal with module present and enabled.
	// Three stages, and a change counts once the last two agree, so a
	// one-cycle glitch on the slow level never reaches the clock select.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hib_p_sync <= 3'h0;
			hib_e_sync <= 3'h0;
			hib_ok <= 1'b0;
		end else begin
			hib_p_sync <= {hib_p_sync[1:0], hib_present};
			hib_e_sync <= {hib_e_sync[1:0], hib_enabled};
			// Hold the last trusted value while the stages disagree
			if (hib_p_sync[2] == hib_p_sync[1] &&
				hib_e_sync[2] == hib_e_sync[1]) begin
				hib_ok <= hib_p_sync[2] & hib_e_sync[2];
			end
		end
	end

	// Choose legacy or new divider form; fall back to precision osc
	// when hibernation source is not usable. A hibernation clock that
	// goes away while asleep drops to the precision osc four edges after it is first sampled.
	assign eff_src = (sleep_src == `DSLP_SRC_HIB && !hib_ok) ?
		`DSLP_SRC_PREC : sleep_src;
	assign eff_div = use_legacy ? {4'h0, legacy_div} : sleep_div;

	// An oscillator that clocks the sleeping system stays up whatever
	// software asked; the power-down bit only stops an idle one
	wire next_precision_on = !(sleep_precision_osc_powerdown &&
		eff_src != `DSLP_SRC_PREC);
	wire next_main_on = !(sleep_main_osc_powerdown &&
		eff_src != `DSLP_SRC_MAIN);
	// Gating off keeps every run-mode clock alive in deep sleep
	wire [31:0] next_sleep_periph = clock_gating ? periph_sleep_en :
		periph_run_en;

	// Bus writes land in the data phase. The address is captured every
	// cycle; wr_pend alone decides whether the data phase writes.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			sleep_div <= `DSLP_RST_DIV;
			sleep_src <= `DSLP_SRC_MAIN;
			sleep_precision_osc_powerdown <= 1'b0;
			sleep_main_osc_powerdown <= 1'b0;
			use_legacy <= 1'b0;
			legacy_div <= 6'h00;
			flash_low <= 1'b0;
			sram_cfg <= `DSLP_SRAM_FULL;
			ldo_sleep <= 1'b0;
			temp_low <= 1'b0;
			clock_gating <= 1'b0;
			port_ahb_sel <= `DSLP_RST_PORTBUS;
			run_src <= `DSLP_SRC_MAIN;
			run_div <= 10'h000;
			periph_sleep_en <= 32'h00000000;
			ahb_only <= `DSLP_RST_AHBONLY;
		end else begin
			wr_pend <= addr_ok && hwrite;
			wr_addr <= a;
			if (wr_pend) begin
				if (wr_addr == `DSLP_OFF_CLKCFG) begin
					// Divider stored as value minus one
					sleep_div <= hwdata[`DSLP_DIV_MSB:`DSLP_DIV_LSB];
					sleep_src <= hwdata[`DSLP_SRC_MSB:`DSLP_SRC_LSB];
					sleep_precision_osc_powerdown <=
						hwdata[`DSLP_PIOPD_BIT];
					sleep_main_osc_powerdown <= hwdata[`DSLP_MOPD_BIT];
					use_legacy <= 1'b0;
				end else if (wr_addr == `DSLP_OFF_LEGCFG) begin
					legacy_div <= hwdata[`DSLP_LEGDIV_MSB:0];
					sleep_src <= hwdata[`DSLP_SRC_MSB:`DSLP_SRC_LSB];
					sleep_precision_osc_powerdown <=
						hwdata[`DSLP_PIOPD_BIT];
					// Legacy form has no main power-down; a stale one
					// from the new form must not stop the main osc
					sleep_main_osc_powerdown <= 1'b0;
					use_legacy <= 1'b1;
				end else if (wr_addr == `DSLP_OFF_PWRCFG) begin
					flash_low <= hwdata[`DSLP_FLASH_BIT];
					// Encoding 2 is not a level; treat as standby
					sram_cfg <= (hwdata[`DSLP_SRAM_MSB:`DSLP_SRAM_LSB] ==
						2'h2) ? `DSLP_SRAM_STBY :
						hwdata[`DSLP_SRAM_MSB:`DSLP_SRAM_LSB];
					ldo_sleep <= hwdata[`DSLP_LDO_BIT];
					temp_low <= hwdata[`DSLP_TEMP_BIT];
					clock_gating <= hwdata[`DSLP_GATE_BIT];
				end else if (wr_addr == `DSLP_OFF_PORTBUS) begin
					// Both fields move together so no port sits between
					port_ahb_sel <= hwdata[`DSLP_PORT_MSB:0];
					ahb_only <=
						hwdata[`DSLP_AHBONLY_MSB:`DSLP_AHBONLY_LSB];
				end else if (wr_addr == `DSLP_OFF_RUNCFG) begin
					// Run setup may change in either mode; asleep it waits
					run_div <= hwdata[`DSLP_DIV_MSB:`DSLP_DIV_LSB];
					run_src <= hwdata[`DSLP_SRC_MSB:`DSLP_SRC_LSB];
				end else if (wr_addr == `DSLP_OFF_PERIPH) begin
					// Only used while gating is on in deep sleep
					periph_sleep_en <= hwdata;
				end
			end
		end
	end

	// Read data and response; zero-wait, unmapped reads give zero.
	// Data is launched at the address-phase edge, so the master's
	// data-phase sample sees it with no wait state inserted.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_ok && !hwrite) begin
				if (a == `DSLP_OFF_CLKCFG) begin
					hrdata <= {14'h0000, sleep_main_osc_powerdown,
						sleep_precision_osc_powerdown, 2'h0, sleep_src,
						2'h0, sleep_div};
				end else if (a == `DSLP_OFF_LEGCFG) begin
					hrdata <= {15'h0000, sleep_precision_osc_powerdown,
						2'h0, sleep_src, 6'h00, legacy_div};
				end else if (a == `DSLP_OFF_PWRCFG) begin
					hrdata <= {19'h00000, clock_gating, 2'h0, temp_low,
						ldo_sleep, 2'h0, sram_cfg, 3'h0, flash_low};
				end else if (a == `DSLP_OFF_PORTBUS) begin
					hrdata <= {7'h00, ahb_only, 7'h00, port_ahb_sel};
				end else if (a == `DSLP_OFF_STATUS) begin
					// Snapshot of hib_ok, the core sleep level and the registered outputs at this edge
					hrdata <= {24'h000000, hib_ok, in_sleep, main_osc_on,
						precision_osc_on, 2'h0, clk_src_sel};
				end else if (a == `DSLP_OFF_FLASHSZ) begin
					hrdata <= `DSLP_FLASH_SIZE;
				end else if (a == `DSLP_OFF_SECTSZ) begin
					hrdata <= `DSLP_SECT_SIZE;
				end else if (a == `DSLP_OFF_RUNCFG) begin
					hrdata <= {18'h00000, run_src, 2'h0, run_div};
				end else if (a == `DSLP_OFF_PERIPH) begin
					hrdata <= periph_sleep_en;
				end else begin
					hrdata <= 32'h00000000;
				end
			end
		end
	end

	// Clock, oscillator and power outputs. Sleep settings only act
	// while the core sleeps so run mode comes back on wake. Registered
	// so clock and analog blocks see no decode glitches, at one cycle.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			// Both oscillators run: nothing may start from a dead clock
			clk_src_sel <= `DSLP_SRC_MAIN;
			clk_div_m1 <= 10'h000;
			precision_osc_on <= 1'b1;
			main_osc_on <= 1'b1;
			flash_reduced_power <= 1'b0;
			sram_power <= `DSLP_SRAM_FULL;
			regulator_sleep_mode <= 1'b0;
			temp_sensor_reduced_power <= 1'b0;
			periph_clk_en <= 32'h00000000;
		end else if (in_sleep) begin
			clk_src_sel <= eff_src;
			clk_div_m1 <= eff_div;
			precision_osc_on <= next_precision_on;
			main_osc_on <= next_main_on;
			flash_reduced_power <= flash_low;
			sram_power <= sram_cfg;
			regulator_sleep_mode <= ldo_sleep;
			temp_sensor_reduced_power <= temp_low;
			periph_clk_en <= next_sleep_periph;
		end else begin
			clk_src_sel <= run_src;
			clk_div_m1 <= run_div;
			precision_osc_on <= 1'b1;
			main_osc_on <= 1'b1;
			flash_reduced_power <= 1'b0;
			sram_power <= `DSLP_SRAM_FULL;
			regulator_sleep_mode <= 1'b0;
			temp_sensor_reduced_power <= 1'b0;
			periph_clk_en <= periph_run_en;
		end
	end

	// Per-port attachment, one slice per port A..I. A port marked
	// high-speed-only has no legacy path, so clearing its high-speed
	// enable leaves it on neither bus.
	genvar gp;
	generate
		for (gp = 0; gp < `DSLP_NPORTS; gp = gp + 1) begin : g_port
			assign next_port_ahb[gp] = port_ahb_sel[gp];
			assign next_port_apb[gp] = !port_ahb_sel[gp] &&
				!ahb_only[gp];
		end
	endgenerate

	// Port attachment flops; reset leaves every port on the legacy bus
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			port_on_ahb <= `DSLP_RST_PORTBUS;
			port_on_apb <= `DSLP_RST_PORTAPB;
		end else begin
			port_on_ahb <= next_port_ahb;
			port_on_apb <= next_port_apb;
		end
	end

endmodule // dslp_ctrl

// File: src/dslp_defines.vh
/*
 Register offsets, field positions, reset values and encodings of the
 deep-sleep clock and power control slice.
 Assumes a 32-bit AHB-Lite bus, word-aligned registers.
*/
`ifndef DSLP_DEFINES_VH
`define DSLP_DEFINES_VH

// Register byte offsets
`define DSLP_OFF_CLKCFG 12'h000
`define DSLP_OFF_LEGCFG 12'h004
`define DSLP_OFF_PWRCFG 12'h008
`define DSLP_OFF_PORTBUS 12'h00c
`define DSLP_OFF_STATUS 12'h010
`define DSLP_OFF_FLASHSZ 12'h014
`define DSLP_OFF_SECTSZ 12'h018
`define DSLP_OFF_RUNCFG 12'h01c
`define DSLP_OFF_PERIPH 12'h020

// Clock configuration fields
`define DSLP_DIV_LSB 0
`define DSLP_DIV_MSB 9
`define DSLP_SRC_LSB 12
`define DSLP_SRC_MSB 13
`define DSLP_PIOPD_BIT 16
`define DSLP_MOPD_BIT 17
`define DSLP_LEGDIV_MSB 5

// Power configuration fields
`define DSLP_FLASH_BIT 0
`define DSLP_SRAM_LSB 4
`define DSLP_SRAM_MSB 5
`define DSLP_LDO_BIT 8
`define DSLP_TEMP_BIT 9
`define DSLP_GATE_BIT 12

// Port bus fields
`define DSLP_PORT_MSB 8
`define DSLP_AHBONLY_LSB 16
`define DSLP_AHBONLY_MSB 24

// Source encodings
`define DSLP_SRC_MAIN 2'h0
`define DSLP_SRC_PREC 2'h1
`define DSLP_SRC_LFI 2'h2
`define DSLP_SRC_HIB 2'h3

// SRAM power levels
`define DSLP_SRAM_FULL 2'h0
`define DSLP_SRAM_STBY 2'h1
`define DSLP_SRAM_LOW 2'h3

// Reset values, size constants and port count
`define DSLP_RST_DIV 10'h000
`define DSLP_RST_PORTBUS 9'h000
`define DSLP_RST_AHBONLY 9'h000
`define DSLP_RST_PORTAPB 9'h1ff
`define DSLP_FLASH_SIZE 32'h00040000
`define DSLP_SECT_SIZE 32'h00000400
`define DSLP_NPORTS 9

`endif

// File: test/dslp_core_model.sv
/*
 Model of the processor core on the sleep side of the slice.
 Assumes the bench asks for sleep with a level; the core answers on clk.
*/
`timescale 1ns/1ps
module dslp_core_model (
	input wire clk,
	input wire rst,
	input wire sleep_req,
	output reg core_deep_sleep
);
	// Level moves only at an edge, so the slice never sees a runt
	always @(posedge clk or posedge rst) begin
		if (rst)
			core_deep_sleep <= 1'b0;
		else
			core_deep_sleep <= sleep_req;
	end
endmodule // dslp_core_model

// File: test/dslp_ctrl_asserts.sv
/*
 Concurrent checks on the ports of the deep-sleep control slice.
 Assumes one clock domain and the bench's bind by name.
*/
`timescale 1ns/1ps
module dslp_ctrl_asserts (
	input wire clk,
	input wire rst,
	input wire hreadyout,
	input wire hresp,
	input wire core_deep_sleep,
	input wire [31:0] periph_run_en,
	input wire [1:0] clk_src_sel,
	input wire [9:0] clk_div_m1,
	input wire precision_osc_on,
	input wire main_osc_on,
	input wire flash_reduced_power,
	input wire [1:0] sram_power,
	input wire regulator_sleep_mode,
	input wire temp_sensor_reduced_power,
	input wire [31:0] periph_clk_en,
	input wire [8:0] port_on_ahb,
	input wire [8:0] port_on_apb
);
	default clocking dslp_cb @(posedge clk); endclocking
	default disable iff (rst);
	// Zero-wait slave, always OKAY
	ready_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	port_exclusive_a: assert property (
		(port_on_ahb & port_on_apb) == 9'h000)
		else $error("port on both buses");
	src_osc_on_a: assert property (
		(clk_src_sel == 2'h0 |-> main_osc_on)
		and (clk_src_sel == 2'h1 |-> precision_osc_on))
		else $error("selected oscillator is off");
	sram_code_a: assert property (sram_power != 2'h2)
		else $error("unknown sram level");
	// Run-mode checks skip the edge right after reset, still reset values
	run_osc_a: assert property (!$past(rst) && !$past(core_deep_sleep)
		|-> precision_osc_on && main_osc_on) else $error("osc off in run");
	run_power_a: assert property (!$past(rst) && !$past(core_deep_sleep)
		|-> {flash_reduced_power, sram_power, regulator_sleep_mode,
		temp_sensor_reduced_power} == 5'h00) else $error("low power in run");
	run_periph_a: assert property (!$past(rst) && !$past(core_deep_sleep)
		|-> periph_clk_en == $past(periph_run_en))
		else $error("run clocks not followed");
	run_stable_a: assert property (!$past(rst) && !$past(rst, 2)
		&& !$past(core_deep_sleep) && !$past(core_deep_sleep, 2)
		|-> $stable(clk_src_sel) && $stable(clk_div_m1))
		else $error("run clock moved without wake");
endmodule // dslp_ctrl_asserts

// File: test/dslp_ctrl_bench.sv
/*
 Self-checking bench of the deep-sleep control slice.
 Assumes the designer's zero-wait AHB-Lite slave and register map.
*/
`timescale 1ns/1ps
`include "dslp_defines.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	$display("wrong value %s exp %h got %h", n, e, g); error_cnt++; end end
module dslp_ctrl_bench;
	typedef struct packed {
		logic [31:0] a, c, p;
		logic h;
		logic [1:0] s;
		logic [9:0] d;
		logic [1:0] o;
		logic [4:0] w;
	} dslp_row_t;
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic sleep_req = 1'b0, hib_present = 1'b0, hib_enabled = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [31:0] periph_run_en = 32'h000000ff;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	wire [31:0] hrdata, periph_clk_en;
	wire hreadyout, hresp, core_deep_sleep, precision_osc_on, main_osc_on;
	wire flash_reduced_power, regulator_sleep_mode, temp_sensor_reduced_power;
	wire [1:0] clk_src_sel, sram_power;
	wire [9:0] clk_div_m1;
	wire [8:0] port_on_ahb, port_on_apb;
	wire hready = hreadyout;
	wire [18:0] seen = {clk_src_sel, clk_div_m1, precision_osc_on,
		main_osc_on, flash_reduced_power, sram_power, regulator_sleep_mode,
		temp_sensor_reduced_power};
	int error_cnt = 0, compares = 0;
	// Config address and word, power word, hib ok, then expected sleep outputs
	dslp_row_t rows [7] = '{
		'{32'h0, 32'h000103ff, 32'h1, 1'h0, 2'h0, 10'h3ff, 2'h1, 5'h10},
		'{32'h0, 32'h00031000, 32'h10, 1'h0, 2'h1, 10'h0, 2'h2, 5'h04},
		'{32'h0, 32'h00022000, 32'h330, 1'h0, 2'h2, 10'h0, 2'h2, 5'h0f},
		'{32'h0, 32'h00020000, 32'h20, 1'h0, 2'h0, 10'h0, 2'h3, 5'h04},
		'{32'h4, 32'h0001103f, 32'h0, 1'h0, 2'h1, 10'h03f, 2'h3, 5'h00},
		'{32'h0, 32'h00033000, 32'h0, 1'h0, 2'h1, 10'h0, 2'h2, 5'h00},
		'{32'h0, 32'h00033000, 32'h0, 1'h1, 2'h3, 10'h0, 2'h0, 5'h00}};
	dslp_ctrl DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .core_deep_sleep(core_deep_sleep),
		.hib_present(hib_present), .hib_enabled(hib_enabled),
		.periph_run_en(periph_run_en), .clk_src_sel(clk_src_sel),
		.clk_div_m1(clk_div_m1), .precision_osc_on(precision_osc_on),
		.main_osc_on(main_osc_on),
		.flash_reduced_power(flash_reduced_power),
		.sram_power(sram_power),
		.regulator_sleep_mode(regulator_sleep_mode),
		.temp_sensor_reduced_power(temp_sensor_reduced_power),
		.periph_clk_en(periph_clk_en), .port_on_ahb(port_on_ahb),
		.port_on_apb(port_on_apb));
	dslp_core_model core (.clk(clk), .rst(rst), .sleep_req(sleep_req),
		.core_deep_sleep(core_deep_sleep));
	always #5 clk = ~clk;
	// Watchdog well past the roughly 105 cycles the run needs
	initial begin
		#200000;
		error_cnt++;
		final_report;
	end
	task final_report;
		if (error_cnt == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One single AHB-Lite transfer; waits on hready, never on a count
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// Core level change plus the model and slice edges behind it
	task nap(input logic on);
		sleep_req <= on;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("reset ports", 18'h001ff, {port_on_ahb, port_on_apb})
		bus(1'b1, 32'h20, 32'h5);
		foreach (rows[i]) begin
			hib_present <= rows[i].h;
			hib_enabled <= rows[i].h;
			bus(1'b1, rows[i].a, rows[i].c);
			bus(1'b1, 32'h8, rows[i].p);
			`CHK("run before", 19'h00060, seen)
			nap(1'b1);
			`CHK("sleep clock", rows[i][18:7], seen[18:7])
			`CHK("sleep osc", rows[i][6:5], seen[6:5])
			`CHK("sleep power", rows[i][4:0], seen[4:0])
			`CHK("ungated clocks", 32'hff, periph_clk_en)
			nap(1'b0);
			`CHK("run cfg", 19'h00060, seen)
		end
		// Gating on: only the sleep-enabled peripherals keep clocks
		bus(1'b1, 32'h8, 32'h1000);
		nap(1'b1);
		`CHK("gated clocks", 32'h5, periph_clk_en)
		// Run setup rewritten while asleep must show only after waking
		bus(1'b1, 32'h1c, 32'h00002005);
		`CHK("run held in sleep", 2'h3, clk_src_sel)
		nap(1'b0);
		`CHK("run restored", 12'h805, {clk_src_sel, clk_div_m1})
		periph_run_en <= 32'h0000f0f0;
		repeat (2) @(posedge clk);
		`CHK("run clocks", 32'h0000f0f0, periph_clk_en)
		bus(1'b0, 32'h10, 32'h0);
		`CHK("status", 32'h000000b2, rd)
		bus(1'b0, 32'h8, 32'h0);
		`CHK("power readback", 32'h00001000, rd)
		bus(1'b1, 32'hc, 32'h00030005);
		repeat (2) @(posedge clk);
		`CHK("port bus", 18'h00bf8, {port_on_ahb, port_on_apb})
		bus(1'b0, 32'h14, 32'h0);
		`CHK("flash size", `DSLP_FLASH_SIZE, rd)
		bus(1'b0, 32'h18, 32'h0);
		`CHK("sector size", `DSLP_SECT_SIZE, rd)
		bus(1'b0, 32'h40, 32'h0);
		`CHK("unmapped read", 32'h0, rd)
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("second reset", 18'h001ff, {port_on_ahb, port_on_apb})
		`CHK("reset clocks", 19'h00060, seen)
		final_report;
	end
endmodule // dslp_ctrl_bench
bind dslp_ctrl dslp_ctrl_asserts chk (.clk(clk), .rst(rst),
	.hreadyout(hreadyout), .hresp(hresp),
	.core_deep_sleep(core_deep_sleep), .periph_run_en(periph_run_en),
	.clk_src_sel(clk_src_sel), .clk_div_m1(clk_div_m1),
	.precision_osc_on(precision_osc_on), .main_osc_on(main_osc_on),
	.flash_reduced_power(flash_reduced_power), .sram_power(sram_power),
	.regulator_sleep_mode(regulator_sleep_mode),
	.temp_sensor_reduced_power(temp_sensor_reduced_power),
	.periph_clk_en(periph_clk_en), .port_on_ahb(port_on_ahb),
	.port_on_apb(port_on_apb));
